// ---- core/cct_pkg.sv ----
`default_nettype none
// ============================================================
// Shared constants of the capture timer mode control
package cct_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0]  IDX_MODE_CTRL   = 8'h01;
    localparam logic [7:0]  IDX_EVENT_CTRL  = 8'h04;
    localparam logic [7:0]  IDX_IRQ_ENABLE  = 8'h05;
    localparam logic [7:0]  IDX_IRQ_FLAGS   = 8'h06;
    localparam logic [7:0]  IDX_STATUS      = 8'h07;
    // Field positions, mode and output control
    localparam int          MC_MODE_LSB     = 0;
    localparam int          MC_OVERRIDE_BIT = 4;
    localparam int          MC_INIT_BIT     = 5;
    localparam int          MC_IMMED_BIT    = 6;
    // Field positions, event control
    localparam int          EV_GATE_BIT     = 0;
    localparam int          EV_EDGE_BIT     = 4;
    localparam int          EV_FILTER_BIT   = 6;
    // Field positions, interrupt enable and flags
    localparam int          IRQ_CAPTURE_IRQ_BIT    = 0;
    localparam int          IRQ_OVF_BIT     = 1;
    // Writable bit masks, others read as zero
    localparam logic [7:0]  MC_MASK         = 8'h77;
    localparam logic [7:0]  EV_MASK         = 8'h51;
    localparam logic [7:0]  IRQ_MASK        = 8'h03;
    // Reset values
    localparam logic [7:0]  MC_RESET        = 8'h00;
    localparam logic [7:0]  EV_RESET        = 8'h00;
    localparam logic [7:0]  IRQ_EN_RESET    = 8'h00;
    localparam logic [7:0]  IRQ_FLAG_RESET  = 8'h00;
    // Bus responses
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
    // Timing counts in peripheral clocks
    localparam int          FILTER_SAMPLES  = 4;
    localparam int          SYNC_STAGES     = 2;
    // Counter modes
    typedef enum logic [2:0] {
        MODE_PERIODIC          = 3'b000,
        MODE_TIMEOUT           = 3'b001,
        MODE_CAPTURE           = 3'b010,
        MODE_PERIOD_MEASURE    = 3'b011,
        MODE_WIDTH_MEASURE     = 3'b100,
        MODE_PERIOD_AND_WIDTH  = 3'b101,
        MODE_SINGLE_SHOT       = 3'b110,
        MODE_BYTE_PWM          = 3'b111
    } cct_mode_t;
    // Combined measurement sequence
    typedef enum logic [1:0] {
        PW_IDLE                = 2'b00,
        PW_WAIT_CAPTURE        = 2'b01,
        PW_WAIT_STOP           = 2'b10
    } cct_pw_state_t;
endpackage : cct_pkg
`default_nettype wire

// ---- core/cct_capture_timer.sv ----
`default_nettype none
module cct_capture_timer #(
    parameter int FILTER_SAMPLES = cct_pkg::FILTER_SAMPLES,
    parameter int SYNC_STAGES    = cct_pkg::SYNC_STAGES
) (
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        sys_rst_i,
    // AXI4-Lite write address
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    // AXI4-Lite write data
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    // AXI4-Lite read data
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // Event from the routing network
    input  wire logic        capture_event_i,
    // Counter status from the counter
    input  wire logic        counter_wrap_i,
    input  wire logic        counter_at_top_i,
    input  wire logic        capture_read_i,
    // Counter commands
    output logic             counter_start_o,
    output logic             counter_stop_o,
    output logic             counter_clear_o,
    output logic             capture_load_o,
    output logic [2:0]       counter_mode_select_o,
    // Pin path
    input  wire logic        port_out_i,
    output logic             pin_out_o,
    output logic             waveform_pin_override_o,
    // Interrupt requests
    output logic             capture_irq_o,
    output logic             overflow_irq_o
);
    // ========================================================
    // Register state
    logic [7:0]              mode_ctrl_r;        // Mode and output control
    logic [7:0]              event_ctrl_r;       // Event control
    logic [7:0]              irq_enable_r;       // Interrupt enables
    logic [7:0]              irq_flags_r;        // Sticky flags
    logic [7:0]              irq_flags_nxt;      // Flags next value
    logic                    running_r;          // Counter run state
    logic                    mode_write;         // Mode register written
    logic                    flag_write;         // Flag register written
    logic [7:0]              wr_idx;             // Write index
    logic [7:0]              rd_idx;             // Read index
    logic                    wr_fire;            // Write accepted
    logic                    rd_fire;            // Read accepted
    logic [7:0]              rd_value;           // Read mux result
    logic                    rd_hit;             // Read address mapped
    logic                    wr_hit;             // Write address mapped

    // Decoded fields
    cct_pkg::cct_mode_t      mode;
    logic                    edge_sel;
    logic                    gate_on;
    logic                    filter_on;
    logic                    immed_on;
    logic                    override_on;

    assign mode        = cct_pkg::cct_mode_t'(mode_ctrl_r[cct_pkg::MC_MODE_LSB +: 3]);
    assign edge_sel    = event_ctrl_r[cct_pkg::EV_EDGE_BIT];
    assign gate_on     = event_ctrl_r[cct_pkg::EV_GATE_BIT];
    assign filter_on   = event_ctrl_r[cct_pkg::EV_FILTER_BIT];
    assign immed_on    = mode_ctrl_r[cct_pkg::MC_IMMED_BIT];
    assign override_on = mode_ctrl_r[cct_pkg::MC_OVERRIDE_BIT];
    assign counter_mode_select_o = mode_ctrl_r[cct_pkg::MC_MODE_LSB +: 3];

    // ========================================================
    // Bus slave
    // Write taken only with address and data together
    assign wr_fire       = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wr_fire;
    assign s_axi_wready  = wr_fire;
    assign rd_fire       = s_axi_arvalid && !s_axi_rvalid;
    assign s_axi_arready = rd_fire;
    assign wr_idx        = s_axi_awaddr[9:2];
    assign rd_idx        = s_axi_araddr[9:2];
    assign mode_write    = wr_fire && s_axi_wstrb[0] && (wr_idx == cct_pkg::IDX_MODE_CTRL);
    assign flag_write    = wr_fire && s_axi_wstrb[0] && (wr_idx == cct_pkg::IDX_IRQ_FLAGS);

    // Write address decode
    assign wr_hit = wr_idx inside {cct_pkg::IDX_MODE_CTRL, cct_pkg::IDX_EVENT_CTRL,
                                   cct_pkg::IDX_IRQ_ENABLE, cct_pkg::IDX_IRQ_FLAGS,
                                   cct_pkg::IDX_STATUS};

    // Write response, error for unmapped words
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= cct_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? cct_pkg::RESP_OKAY : cct_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Control register writes, lane 0 only
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            mode_ctrl_r  <= cct_pkg::MC_RESET;
            event_ctrl_r <= cct_pkg::EV_RESET;
            irq_enable_r <= cct_pkg::IRQ_EN_RESET;
        end else if (wr_fire && s_axi_wstrb[0]) begin
            case (wr_idx)
                cct_pkg::IDX_MODE_CTRL:  mode_ctrl_r  <= s_axi_wdata[7:0] & cct_pkg::MC_MASK;
                cct_pkg::IDX_EVENT_CTRL: event_ctrl_r <= s_axi_wdata[7:0] & cct_pkg::EV_MASK;
                cct_pkg::IDX_IRQ_ENABLE: irq_enable_r <= s_axi_wdata[7:0] & cct_pkg::IRQ_MASK;
                default:                 ;
            endcase
        end
    end

    // Read mux
    always_comb begin
        rd_hit   = 1'b1;
        rd_value = 8'h00;
        case (rd_idx)
            cct_pkg::IDX_MODE_CTRL:  rd_value = mode_ctrl_r;
            cct_pkg::IDX_EVENT_CTRL: rd_value = event_ctrl_r;
            cct_pkg::IDX_IRQ_ENABLE: rd_value = irq_enable_r;
            cct_pkg::IDX_IRQ_FLAGS:  rd_value = irq_flags_r;
            cct_pkg::IDX_STATUS:     rd_value = {7'h00, running_r};
            default:                 rd_hit   = 1'b0;
        endcase
    end

    // Read data channel
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= cct_pkg::RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rd_value};
            s_axi_rresp  <= rd_hit ? cct_pkg::RESP_OKAY : cct_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ========================================================
    // Event conditioning
    logic [FILTER_SAMPLES-1:0] filt_hist_r;     // Recent raw samples
    logic                      filt_level_r;    // Filtered level
    logic                      evt_level;       // Level used for edges
    logic                      evt_prev_r;      // Previous used level
    logic                      rise;            // Rising edge seen
    logic                      fall;            // Falling edge seen
    logic                      act_rise;        // Selected-polarity edge
    logic                      act_fall;        // Opposite edge

    // Noise canceller: level follows only a stable run of samples
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            filt_hist_r  <= '0;
            filt_level_r <= 1'b0;
        end else begin
            filt_hist_r <= {filt_hist_r[FILTER_SAMPLES-2:0], capture_event_i};
            if (&filt_hist_r) begin
                filt_level_r <= 1'b1;
            end else if (~|filt_hist_r) begin
                filt_level_r <= 1'b0;
            end
        end
    end

    assign evt_level = filter_on ? filt_level_r : capture_event_i;

    // Edge history
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            evt_prev_r <= 1'b0;
        end else begin
            evt_prev_r <= evt_level;
        end
    end

    // Edges count only while the input gate is open
    assign rise     = gate_on && evt_level && !evt_prev_r;
    assign fall     = gate_on && !evt_level && evt_prev_r;
    // Edge bit picks which edge is the primary one
    assign act_rise = edge_sel ? fall : rise;
    assign act_fall = edge_sel ? rise : fall;

    // ========================================================
    // Mode actions
    cct_pkg::cct_pw_state_t  pw_state_r;         // Combined sequence state
    logic                    do_start;
    logic                    do_stop;
    logic                    do_clear;
    logic                    do_capture;
    logic                    capture_irq_event;         // Capture flag source
    logic                    shot_trigger;       // Single-shot event
    logic [SYNC_STAGES-1:0]  shot_pipe_r;        // Start sync delay

    // Single shot takes the rising edge, or both with edge bit set
    assign shot_trigger = (mode == cct_pkg::MODE_SINGLE_SHOT) && (rise || (edge_sel && fall));

    // Per-mode event decoding
    always_comb begin
        do_start   = 1'b0;
        do_stop    = 1'b0;
        do_clear   = 1'b0;
        do_capture = 1'b0;
        capture_irq_event = 1'b0;
        case (mode)
            cct_pkg::MODE_PERIODIC: begin
                capture_irq_event = counter_at_top_i;
            end
            cct_pkg::MODE_TIMEOUT: begin
                do_start   = act_rise;
                do_stop    = act_fall;
                capture_irq_event = counter_at_top_i;
            end
            cct_pkg::MODE_CAPTURE: begin
                do_capture = act_rise;
                capture_irq_event = act_rise;
            end
            cct_pkg::MODE_PERIOD_MEASURE: begin
                do_capture = act_rise;
                do_clear   = act_rise;
                do_start   = act_rise;
                capture_irq_event = act_rise;
            end
            cct_pkg::MODE_WIDTH_MEASURE: begin
                do_clear   = act_rise;
                do_start   = act_rise;
                do_capture = act_fall;
                capture_irq_event = act_fall;
            end
            cct_pkg::MODE_PERIOD_AND_WIDTH: begin
                case (pw_state_r)
                    cct_pkg::PW_IDLE: begin
                        do_clear = act_rise;
                        do_start = act_rise;
                    end
                    cct_pkg::PW_WAIT_CAPTURE: begin
                        do_capture = act_fall;
                    end
                    cct_pkg::PW_WAIT_STOP: begin
                        do_stop    = act_rise;
                        capture_irq_event = act_rise;
                    end
                    default: ;
                endcase
            end
            cct_pkg::MODE_SINGLE_SHOT: begin
                do_start   = shot_pipe_r[SYNC_STAGES-1] && !running_r;
                capture_irq_event = counter_at_top_i;
            end
            cct_pkg::MODE_BYTE_PWM: begin
                capture_irq_event = counter_at_top_i;
            end
            default: ;
        endcase
    end

    // Combined measurement sequencer, restarted by a mode write
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || mode_write || mode != cct_pkg::MODE_PERIOD_AND_WIDTH) begin
            pw_state_r <= cct_pkg::PW_IDLE;
        end else begin
            case (pw_state_r)
                cct_pkg::PW_IDLE:         if (act_rise) pw_state_r <= cct_pkg::PW_WAIT_CAPTURE;
                cct_pkg::PW_WAIT_CAPTURE: if (act_fall) pw_state_r <= cct_pkg::PW_WAIT_STOP;
                cct_pkg::PW_WAIT_STOP:    if (act_rise) pw_state_r <= cct_pkg::PW_IDLE;
                default:                  pw_state_r <= cct_pkg::PW_IDLE;
            endcase
        end
    end

    // Single-shot start synchroniser delay
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            shot_pipe_r <= '0;
        end else begin
            shot_pipe_r <= {shot_pipe_r[SYNC_STAGES-2:0], shot_trigger};
        end
    end

    // Run state seen by software; single shot ends at top
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || mode_write) begin
            running_r <= 1'b0;
        end else if (do_start) begin
            running_r <= 1'b1;
        end else if (do_stop || (mode == cct_pkg::MODE_SINGLE_SHOT && counter_at_top_i)) begin
            running_r <= 1'b0;
        end
    end

    // Command strobes to the counter
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            counter_start_o <= 1'b0;
            counter_stop_o  <= 1'b0;
            counter_clear_o <= 1'b0;
            capture_load_o  <= 1'b0;
        end else begin
            counter_start_o <= do_start;
            counter_stop_o  <= do_stop;
            counter_clear_o <= do_clear;
            capture_load_o  <= do_capture;
        end
    end

    // ========================================================
    // Interrupt flags; a set in the clearing cycle wins
    logic capture_irq_mode;
    assign capture_irq_mode = mode inside {[cct_pkg::MODE_CAPTURE:cct_pkg::MODE_PERIOD_AND_WIDTH]};

    always_comb begin
        irq_flags_nxt = irq_flags_r;
        if (flag_write) begin
            irq_flags_nxt = irq_flags_r & ~(s_axi_wdata[7:0] & cct_pkg::IRQ_MASK);
        end
        if (capture_read_i && capture_irq_mode) begin
            irq_flags_nxt[cct_pkg::IRQ_CAPTURE_IRQ_BIT] = 1'b0;
        end
        if (counter_wrap_i) begin
            irq_flags_nxt[cct_pkg::IRQ_OVF_BIT] = 1'b1;
        end
        if (capture_irq_event) begin
            irq_flags_nxt[cct_pkg::IRQ_CAPTURE_IRQ_BIT] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            irq_flags_r <= cct_pkg::IRQ_FLAG_RESET;
        end else begin
            irq_flags_r <= irq_flags_nxt;
        end
    end

    // Level requests held while flag and enable are both set
    assign capture_irq_o  = irq_flags_r[cct_pkg::IRQ_CAPTURE_IRQ_BIT]
                          & irq_enable_r[cct_pkg::IRQ_CAPTURE_IRQ_BIT];
    assign overflow_irq_o = irq_flags_r[cct_pkg::IRQ_OVF_BIT]
                          & irq_enable_r[cct_pkg::IRQ_OVF_BIT];

    // ========================================================
    // Waveform generation
    logic wave_r;
    logic init_applies;
    logic immed_set;

    assign init_applies = (mode < cct_pkg::MODE_SINGLE_SHOT);
    assign immed_set    = shot_trigger && immed_on && !running_r;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            wave_r <= 1'b0;
        end else if (mode_write) begin
            // Fresh configuration loads the starting level
            wave_r <= (s_axi_wdata[cct_pkg::MC_MODE_LSB +: 3] < 3'h6)
                    && s_axi_wdata[cct_pkg::MC_INIT_BIT];
        end else if (mode == cct_pkg::MODE_SINGLE_SHOT) begin
            if (immed_set || (do_start && !immed_on)) begin
                wave_r <= 1'b1;
            end else if (counter_at_top_i) begin
                wave_r <= 1'b0;
            end
        end else if (mode == cct_pkg::MODE_BYTE_PWM) begin
            if (counter_wrap_i) begin
                wave_r <= 1'b1;
            end else if (counter_at_top_i) begin
                wave_r <= 1'b0;
            end
        end else if (init_applies && counter_at_top_i) begin
            wave_r <= ~wave_r;
        end
    end

    // Pin mux; direction stays with the port
    assign pin_out_o               = override_on ? wave_r : port_out_i;
    assign waveform_pin_override_o = override_on;

    // Unused inputs
    logic unused_ok;
    assign unused_ok = ^{s_axi_awprot, s_axi_arprot, s_axi_awaddr[31:10], s_axi_awaddr[1:0],
                         s_axi_araddr[31:10], s_axi_araddr[1:0], s_axi_wdata[31:8],
                         s_axi_wstrb[3:1]};
endmodule : cct_capture_timer
`default_nettype wire

// ---- tb/cct_capture_timer_sva.sv ----
`default_nettype none
// ============================================================
// Checker of event actions, pin path and interrupt requests
module cct_capture_timer_sva (
    // Clock, reset and bus write strobe
    input wire logic       sys_clk_i, sys_rst_i, s_axi_wvalid,
    // Event side and counter status
    input wire logic       capture_event_i, counter_wrap_i, capture_read_i,
    // Counter commands
    input wire logic       counter_start_o, counter_clear_o, capture_load_o,
    input wire logic [2:0] counter_mode_select_o,
    // Pin path and requests
    input wire logic       port_out_i, pin_out_o, waveform_pin_override_o,
    input wire logic       capture_irq_o, overflow_irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    // Any change of the routed event level
    sequence s_edge; $changed(capture_event_i); endsequence
    // Edge seen while in a mode that ignores events
    sequence s_idle_edge; counter_mode_select_o inside {3'h0, 3'h7} ##0 s_edge; endsequence
    property p_pin_port; !waveform_pin_override_o |-> pin_out_o == port_out_i; endproperty
    a_pin_port: assert property (p_pin_port)
        else $error("pin not following port output");
    property p_idle_mode;
        s_idle_edge |=> !(counter_start_o || counter_clear_o || capture_load_o);
    endproperty
    a_idle_mode: assert property (p_idle_mode)
        else $error("event acted on in an idle mode");
    property p_load_mode; capture_load_o |-> counter_mode_select_o inside {[3'h2:3'h5]}; endproperty
    a_load_mode: assert property (p_load_mode)
        else $error("capture outside capture modes");
    property p_period_clear;
        capture_load_o && counter_mode_select_o == 3'h3 |-> counter_clear_o;
    endproperty
    a_period_clear: assert property (p_period_clear)
        else $error("period capture without clear");
    property p_width_split;
        capture_load_o && counter_mode_select_o == 3'h4 |-> !counter_clear_o;
    endproperty
    a_width_split: assert property (p_width_split)
        else $error("width capture and clear on one edge");
    property p_ovf_hold; overflow_irq_o && !s_axi_wvalid |=> overflow_irq_o; endproperty
    a_ovf_hold: assert property (p_ovf_hold)
        else $error("overflow request dropped");
    property p_capture_irq_hold;
        capture_irq_o && !s_axi_wvalid && !capture_read_i |=> capture_irq_o;
    endproperty
    a_capture_irq_hold: assert property (p_capture_irq_hold)
        else $error("capture request dropped");
    property p_ovf_cause;
        $rose(overflow_irq_o) |-> $past(counter_wrap_i) || $past(s_axi_wvalid);
    endproperty
    a_ovf_cause: assert property (p_ovf_cause)
        else $error("overflow request without wrap");
endmodule : cct_capture_timer_sva
bind cct_capture_timer cct_capture_timer_sva u_sva (.*);
`default_nettype wire

// ---- tb/cct_far_side.sv ----
`default_nettype none
// ============================================================
// Event routing network and pad model
module cct_far_side (
    // Clock and requested event level
    input  wire logic sys_clk_i,
    input  wire logic ev_lvl_i,
    // Pin level and port direction
    input  wire logic pin_i,
    input  wire logic dir_out_i,
    // Routed event and pad level
    output logic      ev_o,
    output logic      pad_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Routed event is synchronous and lasts whole cycles
    always_ff @(posedge sys_clk_i) ev_o <= ev_lvl_i;
    // Pad floats to its pull-up unless the port sets it as output
    assign pad_o = dir_out_i ? pin_i : 1'b1;
endmodule : cct_far_side
`default_nettype wire

// ---- tb/timer_capture_mode_control_test.sv ----
`default_nettype none
// ============================================================
// Self-checking bench of the capture timer mode control
module timer_capture_mode_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i, sys_rst_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [2:0]  s_axi_awprot, s_axi_arprot, counter_mode_select_o;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic capture_event_i, counter_wrap_i, counter_at_top_i, capture_read_i, port_out_i;
    logic counter_start_o, counter_stop_o, counter_clear_o, capture_load_o, pin_out_o;
    logic waveform_pin_override_o, capture_irq_o, overflow_irq_o, ev_lvl, dir_out, pad;
    logic [33:0] exp_q[$];                 // Expected read answers
    int          mismatches, checked, n_load, n_stop, cyc;
    logic [31:0] seed;
    logic [7:0]  d;
    cct_capture_timer dut (.*);
    cct_far_side u_far (.sys_clk_i, .ev_lvl_i(ev_lvl), .pin_i(pin_out_o),
        .dir_out_i(dir_out), .ev_o(capture_event_i), .pad_o(pad));
    // Clock generator
    initial begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end
    task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic end_sim;
        if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    // Bus write, address and data offered together
    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
        s_axi_awaddr <= {22'h0, idx, 2'b00};
        s_axi_wdata  <= {24'h0, v};
        do @(posedge sys_clk_i); while (!(s_axi_awready && s_axi_wready));
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b001;
        do @(posedge sys_clk_i); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask : wr
    // Bus read, expected answer noted for the monitor
    task automatic rd(input logic [7:0] idx, input logic [33:0] exp);
        exp_q.push_back(exp);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr  <= {22'h0, idx, 2'b00};
        do @(posedge sys_clk_i); while (!s_axi_arready);
        {s_axi_arvalid, s_axi_rready} <= 2'b01;
        do @(posedge sys_clk_i); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask : rd
    // Event level held for n cycles
    task automatic ev(input logic lvl, input int n);
        ev_lvl <= lvl;
        repeat (n) @(posedge sys_clk_i);
    endtask : ev
    // Read monitor, pulse counters and hang guard
    always @(posedge sys_clk_i) begin
        if (s_axi_rvalid && s_axi_rready) chk("read", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
        if (!sys_rst_i) n_load += int'(capture_load_o);
        if (!sys_rst_i) n_stop += int'(counter_stop_o);
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            end_sim();
        end
    end
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
        {counter_wrap_i, counter_at_top_i, capture_read_i, port_out_i, ev_lvl} = '0;
        s_axi_wstrb = 4'hf;
        dir_out = 1'b1;
        seed = 32'h104e;
        sys_rst_i = 1'b1;
        repeat (20) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge sys_clk_i);
        rd(cct_pkg::IDX_MODE_CTRL, 34'h0);
        for (int i = 4; i < 7; i++) rd(8'(i), 34'h0);
        rd(8'h02, {cct_pkg::RESP_SLVERR, 32'h0});
        d = 8'($random(seed));
        wr(cct_pkg::IDX_EVENT_CTRL, d);
        rd(cct_pkg::IDX_EVENT_CTRL, {cct_pkg::RESP_OKAY, 24'h0, d & cct_pkg::EV_MASK});
        wr(cct_pkg::IDX_EVENT_CTRL, 8'h01);
        for (int m = 0; m < 8; m++) begin
            wr(cct_pkg::IDX_MODE_CTRL, 8'(m));
            chk("mode", 34'(counter_mode_select_o), 34'(m));
            ev(1'b1, 6);
            ev(1'b0, 6);
        end
        chk("loads", 34'(n_load), 34'd4);
        chk("stops", 34'(n_stop), 34'd1);
        chk("capture_irq irq off", 34'(capture_irq_o), 34'd0);
        wr(cct_pkg::IDX_EVENT_CTRL, 8'h00);
        wr(cct_pkg::IDX_MODE_CTRL, 8'h02);
        ev(1'b1, 6);
        ev(1'b0, 6);
        chk("gated", 34'(n_load), 34'd4);
        wr(cct_pkg::IDX_EVENT_CTRL, 8'h51);
        ev(1'b1, 2);
        ev(1'b0, 12);
        chk("glitch", 34'(n_load), 34'd4);
        ev(1'b1, 12);
        chk("rise edge1", 34'(n_load), 34'd4);
        ev(1'b0, 12);
        chk("fall edge1", 34'(n_load), 34'd5);
        wr(cct_pkg::IDX_IRQ_ENABLE, 8'h03);
        chk("capture_irq irq", 34'(capture_irq_o), 34'd1);
        capture_read_i <= 1'b1;
        @(posedge sys_clk_i);
        capture_read_i <= 1'b0;
        counter_wrap_i <= 1'b1;
        @(posedge sys_clk_i);
        counter_wrap_i <= 1'b0;
        @(posedge sys_clk_i);
        chk("capture_irq read", 34'(capture_irq_o), 34'd0);
        chk("ovf irq", 34'(overflow_irq_o), 34'd1);
        wr(cct_pkg::IDX_IRQ_ENABLE, 8'h01);
        chk("ovf masked", 34'(overflow_irq_o), 34'd0);
        wr(cct_pkg::IDX_IRQ_ENABLE, 8'h03);
        chk("ovf held", 34'(overflow_irq_o), 34'd1);
        wr(cct_pkg::IDX_IRQ_FLAGS, 8'h02);
        rd(cct_pkg::IDX_IRQ_FLAGS, 34'h0);
        port_out_i <= 1'($random(seed));
        wr(cct_pkg::IDX_MODE_CTRL, 8'h30);
        chk("init high", 34'(pad), 34'd1);
        chk("override", 34'(waveform_pin_override_o), 34'd1);
        wr(cct_pkg::IDX_MODE_CTRL, 8'h37);
        chk("pwm init", 34'(pad), 34'd0);
        wr(cct_pkg::IDX_MODE_CTRL, 8'h07);
        chk("port pin", 34'(pad), 34'(port_out_i));
        wr(cct_pkg::IDX_MODE_CTRL, 8'h56);
        ev(1'b1, 8);
        chk("shot high", 34'(pad), 34'd1);
        end_sim();
    end
endmodule : timer_capture_mode_control_test
`default_nettype wire
